// ### core/lgpm_mux.sv
/*
  pin mux for the five low general purpose pins: per-pin mode, serial
  master port alternate functions, stereo shutter output, lane strap.
  assumes pins resolved outside from out/oe, with board pulls on the
  selects and strap pins; serial engine and shutter source on clk_sys.
*/
// Function
// - with the stereo function on pin 4 it drives high for left eye and low for right.
// - pin 4 can instead be the second serial select, driven low to select.
// - pin 3 is the first serial select, driven low to select the power chip.
// - pin 1 drives the serial master clock out.
// - pin 2 drives the serial master data out.
// - pin 0 is sampled as the serial master data input driven by the peripheral.
// - pins 1 and 2 are sampled as inputs during boot to fix the lane count.
// - the lane count is pin 2 high bit, pin 1 low bit, one to four lanes.
// - after boot pins 1 and 2 return to serial clock and data and the strap is ignored.
// - each pin has a software mode of input, output, bidirectional or open-drain.
// - software chooses between plain gpio and the alternate function.
// - an unused pin should be an output at zero, or be pulled when left as input.
`timescale 1ns/10ps
module lgpm_mux (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [14:0] pin_mode,
  input wire logic pin4_alt_sel,
  input wire logic [4:0] gpio_out,
  input wire logic [4:0] pin_in,
  input wire logic stereo_left,
  input wire logic serial_master_clock,
  input wire logic serial_master_data_out,
  input wire logic serial_select_first_n,
  input wire logic serial_select_second_n,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [4:0] gpio_in,
  output logic serial_master_data_in,
  output logic [2:0] lane_count,
  output logic boot_done
);
  // ==========================================================
  // pin input synchronisers
  logic [4:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else if (clk_en) begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // strap sampler
  lgpm_strap_if sif();
  assign sif.strap_pins = {sync2_reg[lgpm_pkg::PIN_DOUT], sync2_reg[lgpm_pkg::PIN_CLK]};

  lgpm_strap u_strap (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .sif(sif)
  );

  // ==========================================================
  // mode decode
  function automatic lgpm_pkg::lgpm_mode_e mode_of(input logic [14:0] m, input int i);
    lgpm_pkg::lgpm_mode_e r;
    r = lgpm_pkg::lgpm_mode_e'(m[3*i +: 3]);
    return r;
  endfunction

  // alternate value for each pin
  function automatic logic alt_value(input int i, input logic p4sel, input logic left,
                                     input logic sck, input logic sdo,
                                     input logic cs0, input logic cs1);
    logic v;
    v = 1'b0;
    case (i)
      lgpm_pkg::PIN_CLK: v = sck;
      lgpm_pkg::PIN_DOUT: v = sdo;
      lgpm_pkg::PIN_SEL0: v = cs0;
      lgpm_pkg::PIN_SEL1: v = (p4sel == lgpm_pkg::PIN4_ALT_SEL1) ? cs1 : left;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // output drive
  logic [4:0] out_reg, out_next, oe_reg, oe_next, gin_reg, gin_next;
  logic din_reg, din_next;

  genvar g;
  generate
    for (g = 0; g < lgpm_pkg::NUM_PINS; g++) begin : g_pin
      always_comb begin
        out_next[g] = 1'b0;
        oe_next[g] = 1'b0;
        gin_next[g] = sync2_reg[g];
        case (mode_of(pin_mode, g))
          lgpm_pkg::LGPM_MODE_OUT, lgpm_pkg::LGPM_MODE_BIDIR: begin
            out_next[g] = gpio_out[g];
            oe_next[g] = 1'b1;
          end
          lgpm_pkg::LGPM_MODE_OD: begin
            // drive only the low level, the pull-up gives high
            out_next[g] = 1'b0;
            oe_next[g] = ~gpio_out[g];
          end
          lgpm_pkg::LGPM_MODE_ALT: begin
            out_next[g] = alt_value(g, pin4_alt_sel, stereo_left, serial_master_clock,
                                    serial_master_data_out, serial_select_first_n,
                                    serial_select_second_n);
            // strap pins stay inputs until boot ends
            oe_next[g] = (g != lgpm_pkg::PIN_DIN) &&
                         (((g != lgpm_pkg::PIN_CLK) && (g != lgpm_pkg::PIN_DOUT)) ||
                          sif.boot_done);
          end
          // input and off modes leave the pin undriven
          default: begin
            out_next[g] = 1'b0;
            oe_next[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // serial data in from pin 0
  always_comb begin
    din_next = sync2_reg[lgpm_pkg::PIN_DIN];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_reg <= 5'h00;
      oe_reg <= 5'h00;
      gin_reg <= 5'h00;
      din_reg <= 1'b0;
    end else if (clk_en) begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      gin_reg <= gin_next;
      din_reg <= din_next;
    end
  end

  logic [2:0] lanes_reg;
  logic done_reg;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lanes_reg <= {1'b0, lgpm_pkg::LANES_RESET} + 3'h1;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      lanes_reg <= sif.lane_count;
      done_reg <= sif.boot_done;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign gpio_in = gin_reg;
  assign serial_master_data_in = din_reg;
  assign lane_count = lanes_reg;
  assign boot_done = done_reg;

  // ==========================================================
  // checks
  reset_undriven_a: assert property (@(posedge clk_sys)
    $past(reset) |-> pin_oe == 5'h00)
    else $error("pins driven after reset");
  strap_input_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sif.boot_done |=> !pin_oe[lgpm_pkg::PIN_CLK] && !pin_oe[lgpm_pkg::PIN_DOUT])
    else $error("strap pin driven during boot");
  clk_alt_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && sif.boot_done && pin_mode[5:3] == 3'h5) |=>
      pin_oe[1] && pin_out[1] == $past(serial_master_clock))
    else $error("serial clock not on pin 1");
  dout_alt_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && sif.boot_done && pin_mode[8:6] == 3'h5) |=>
      pin_oe[2] && pin_out[2] == $past(serial_master_data_out))
    else $error("serial data not on pin 2");
  sel0_alt_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && pin_mode[11:9] == 3'h5) |=>
      pin_oe[3] && pin_out[3] == $past(serial_select_first_n))
    else $error("first select not on pin 3");
  pin4_alt_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && pin_mode[14:12] == 3'h5) |=> pin_oe[4] &&
      pin_out[4] == ($past(pin4_alt_sel) ? $past(serial_select_second_n) : $past(stereo_left)))
    else $error("pin 4 alternate wrong");
  od_low_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && pin_mode[14:12] == 3'h4) |=> !pin_out[4] && pin_oe[4] == !$past(gpio_out[4]))
    else $error("open drain drove high");
  din_path_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en [*4]) |-> serial_master_data_in == $past(pin_in[0], 3))
    else $error("data in path latency wrong");
endmodule

// ### core/lgpm_pkg.sv
/*
  package for the low gpio pin mux: pin indices, mode and function codes,
  reset values and strap timing.
  assumes a 40 MHz clk_sys.
*/
package lgpm_pkg;
  // ==========================================================
  // pins
  localparam int NUM_PINS = 5;
  localparam int PIN_DIN = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_DOUT = 2;
  localparam int PIN_SEL0 = 3;
  localparam int PIN_SEL1 = 4;

  // ==========================================================
  // per-pin mode, software selected
  typedef enum logic [2:0] {
    LGPM_MODE_OFF = 3'h0,
    LGPM_MODE_IN = 3'h1,
    LGPM_MODE_OUT = 3'h2,
    LGPM_MODE_BIDIR = 3'h3,
    LGPM_MODE_OD = 3'h4,
    LGPM_MODE_ALT = 3'h5
  } lgpm_mode_e;

  // alternate function on pin 4
  localparam logic PIN4_ALT_STEREO = 1'h0;
  localparam logic PIN4_ALT_SEL1 = 1'h1;

  // ==========================================================
  // strap timing
  localparam int CLK_MHZ = 40;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] LANES_RESET = 2'h0;

  typedef enum logic [1:0] {
    LGPM_BOOT_WAIT = 2'h0,
    LGPM_BOOT_SAMPLE = 2'h1,
    LGPM_BOOT_DONE = 2'h2
  } lgpm_boot_e;
endpackage

// ### core/lgpm_strap.sv
/*
  boot strap sampler: waits for the pins to settle after reset, samples the
  two strap levels once and holds the lane count.
  assumes strap_pins are already synchronised to clk_sys.
*/
`timescale 1ns/10ps
module lgpm_strap (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  lgpm_strap_if.sampler sif
);
  // ==========================================================
  // boot sequencing
  lgpm_pkg::lgpm_boot_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] lanes_reg, lanes_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    lanes_next = lanes_reg;
    case (state_reg)
      lgpm_pkg::LGPM_BOOT_WAIT: begin
        if (cnt_reg == 8'(lgpm_pkg::STRAP_SETTLE_CYC - 1)) begin
          state_next = lgpm_pkg::LGPM_BOOT_SAMPLE;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      lgpm_pkg::LGPM_BOOT_SAMPLE: begin
        // high bit pin 2, plus one
        lanes_next = {1'b0, sif.strap_pins} + 3'h1;
        state_next = lgpm_pkg::LGPM_BOOT_DONE;
      end
      lgpm_pkg::LGPM_BOOT_DONE: begin
        // later pin levels ignored, lane count frozen
        state_next = lgpm_pkg::LGPM_BOOT_DONE;
      end
      default: begin
        state_next = lgpm_pkg::LGPM_BOOT_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= lgpm_pkg::LGPM_BOOT_WAIT;
      cnt_reg <= 8'h00;
      lanes_reg <= {1'b0, lgpm_pkg::LANES_RESET} + 3'h1;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lanes_reg <= lanes_next;
    end
  end

  assign sif.lane_count = lanes_reg;
  assign sif.boot_done = (state_reg == lgpm_pkg::LGPM_BOOT_DONE);

  // ==========================================================
  // checks
  lane_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && state_reg == lgpm_pkg::LGPM_BOOT_SAMPLE) |=>
      lanes_reg == {1'b0, $past(sif.strap_pins)} + 3'h1)
    else $error("lane count decode wrong");
  lane_frozen_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == lgpm_pkg::LGPM_BOOT_DONE) |=> $stable(lanes_reg))
    else $error("lane count changed after boot");
endmodule

// ### core/lgpm_strap_if.sv
/*
  interface joining the pin mux top to its strap sampler.
  assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface lgpm_strap_if;
  logic [1:0] strap_pins;
  logic [2:0] lane_count;
  logic boot_done;
  modport mux(output strap_pins, input lane_count, input boot_done);
  modport sampler(input strap_pins, output lane_count, output boot_done);
endinterface

// ### verification/lgpm_far_model.sv
/*
  board and power chip model for the low gpio pin mux: pulls and serial
  data return.
  assumes pin_out/pin_oe come straight from the mux.
*/
`timescale 1ns/10ps
module lgpm_far_model (
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [1:0] strap_lvl,
  input wire logic periph_bit,
  output logic [4:0] pin_in
);
  // ==========================================================
  // pin resolution
  logic sel_on;
  logic din_last;
  // idle line shows 0 so the first bit of 1 is really carried by the peripheral
  initial din_last = 1'h1;
  assign sel_on = pin_oe[3] & ~pin_out[3];
  always @* if (sel_on) din_last = periph_bit;
  // peripheral drives data only while selected
  // released line shows the inverse so a stale value never passes
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : (sel_on ? periph_bit : ~din_last);
  // strap resistors on clock and data pins
  assign pin_in[1] = pin_oe[1] ? pin_out[1] : strap_lvl[0];
  assign pin_in[2] = pin_oe[2] ? pin_out[2] : strap_lvl[1];
  assign pin_in[3] = pin_oe[3] ? pin_out[3] : 1'h1;
  assign pin_in[4] = pin_oe[4] ? pin_out[4] : 1'h1;
endmodule

// ### verification/tb_top.sv
/*
  self-checking bench for the low gpio pin mux.
  assumes the far model stands on the pins; serial engine driven here.
*/
`timescale 1ns/10ps
module tb_top;
  // ==========================================================
  // signals
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic clk_en = 1'h1;
  logic [14:0] pin_mode = 15'h0;
  logic alt_sel = 1'h0;
  logic [4:0] gpio_out = 5'h0;
  logic stereo_left = 1'h0;
  logic sck = 1'h0;
  logic sdo = 1'h0;
  logic sel0_n = 1'h1;
  logic sel1_n = 1'h1;
  logic [1:0] strap_lvl = 2'h0;
  logic periph_bit = 1'h0;
  logic [4:0] pin_out, pin_oe, gpio_in, pin_in;
  logic din;
  logic [2:0] lane_count;
  logic boot_done;
  int miscompares = 0;
  int n_checks = 0;

  initial forever #12.5 clk_sys = ~clk_sys;

  lgpm_mux DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .pin_mode(pin_mode),
    .pin4_alt_sel(alt_sel), .gpio_out(gpio_out), .pin_in(pin_in), .stereo_left(stereo_left),
    .serial_master_clock(sck), .serial_master_data_out(sdo),
    .serial_select_first_n(sel0_n), .serial_select_second_n(sel1_n), .pin_out(pin_out),
    .pin_oe(pin_oe), .gpio_in(gpio_in), .serial_master_data_in(din),
    .lane_count(lane_count), .boot_done(boot_done));
  lgpm_far_model far (.pin_out(pin_out), .pin_oe(pin_oe), .strap_lvl(strap_lvl),
    .periph_bit(periph_bit), .pin_in(pin_in));

  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic set_mode(input int p, input lgpm_pkg::lgpm_mode_e m);
    pin_mode[3*p +: 3] = m;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic boot_strap(input int code);
    int i;
    strap_lvl = code[1:0];
    reset = 1'h1;
    pin_mode = 15'h0;
    step(12);
    chk(pin_oe, 5'h0);
    chk({1'h0, boot_done, lane_count}, 5'h1);
    reset = 1'h0;
    // alt already selected: strap pins must still stay released during boot
    set_mode(1, lgpm_pkg::LGPM_MODE_ALT);
    set_mode(2, lgpm_pkg::LGPM_MODE_ALT);
    step(5);
    chk({3'h0, pin_oe[2:1]}, 5'h0);
    for (i = 0; i < 100 && boot_done !== 1'h1; i++) step(1);
    chk({4'h0, boot_done}, 5'h1);
    chk({2'h0, lane_count}, 5'(code + 1));
    strap_lvl = ~code[1:0];
    step(10);
    chk({2'h0, lane_count}, 5'(code + 1));
    chk({3'h0, pin_oe[2:1]}, 5'h3);
  endtask

  task automatic serial_frame;
    int b;
    for (b = 0; b < 4; b++) set_mode(b, lgpm_pkg::LGPM_MODE_ALT);
    sel0_n = 1'h0;
    // link clock only runs inside the frame, 200 ns period
    for (b = 1; b >= 0; b--) begin
      periph_bit = b[0];
      sdo = b[0];
      sck = 1'h1;
      step(4);
      chk({4'h0, pin_out[1]}, 5'h1);
      chk({pin_oe[3:0], pin_out[2]}, {4'he, b[0]});
      chk({3'h0, pin_out[3], din}, {4'h0, b[0]});
      sck = 1'h0;
      step(4);
      chk({4'h0, pin_out[1]}, 5'h0);
    end
    sel0_n = 1'h1;
    step(2);
    chk({4'h0, pin_out[3]}, 5'h1);
  endtask

  task automatic pin4_alt;
    int v;
    set_mode(4, lgpm_pkg::LGPM_MODE_ALT);
    for (v = 0; v < 4; v++) begin
      alt_sel = v[1];
      stereo_left = v[0];
      sel1_n = ~v[0];
      step(3);
      chk({3'h0, pin_oe[4], pin_out[4]}, {3'h0, 1'h1, v[1] ? ~v[0] : v[0]});
    end
  endtask

  task automatic modes;
    lgpm_pkg::lgpm_mode_e ml [5];
    int k;
    int v;
    logic eoe;
    logic epin;
    ml = '{lgpm_pkg::LGPM_MODE_OFF, lgpm_pkg::LGPM_MODE_IN, lgpm_pkg::LGPM_MODE_OUT,
      lgpm_pkg::LGPM_MODE_BIDIR, lgpm_pkg::LGPM_MODE_OD};
    for (k = 0; k < 5; k++) begin
      for (v = 0; v < 2; v++) begin
        set_mode(4, ml[k]);
        gpio_out[4] = v[0];
        eoe = (k == 2 || k == 3) ? 1'h1 : (k == 4) ? ~v[0] : 1'h0;
        epin = eoe ? (k == 4 ? 1'h0 : v[0]) : 1'h1;
        step(5);
        chk({2'h0, pin_oe[4], pin_in[4], gpio_in[4]}, {2'h0, eoe, epin, epin});
      end
    end
  endtask

  task automatic freeze_and_refuse;
    set_mode(4, lgpm_pkg::LGPM_MODE_OUT);
    gpio_out[4] = 1'h0;
    step(2);
    // clock enable low must hold every output
    clk_en = 1'h0;
    gpio_out[4] = 1'h1;
    step(4);
    chk({3'h0, pin_oe[4], pin_out[4]}, 5'h2);
    clk_en = 1'h1;
    step(1);
    chk({3'h0, pin_oe[4], pin_out[4]}, 5'h3);
    // unused mode code leaves the pin released
    pin_mode[14:12] = 3'h6;
    step(2);
    chk({4'h0, pin_oe[4]}, 5'h0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    int c;
    step(1);
    for (c = 0; c < 4; c++) boot_strap(c);
    serial_frame();
    pin4_alt();
    modes();
    freeze_and_refuse();
    tally_and_finish();
  end
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule
